/* File: core/lds_ctrl.sv */
// power-on sequencer and fault control for a four-channel led sink driver
// assumes comparator outputs arrive as synchronous levels on clk_sys_in
`timescale 1ns/1ns

// How it works
// [R1] enable low 32 ms shuts down fully
// [R2] undervoltage holds everything off
// [R3] sinks follow enable level in operation
// [R4] host pwm duty sets average current
// [R5] host raises enable after supplies valid
// [R6] 256 us unused channel detection first
// [R7] 128 ms soft start forces feedback high
// [R8] 32 ms blanking counts only pwm high
// [R9] fault detectors ignored until blanking ends
// [R10] open timer runs below threshold, pwm high
// [R11] 4 us mask after each pwm rise
// [R12] 20 us open time latches fault
// [R13] short timer runs above threshold, pwm high
// [R14] 2 us short time latches fault
// [R15] latched fault clears only by shutdown
// [R16] over-temperature disables channels, not latched
// [R17] short low time is dimming only
// [R18] unused channels excluded from open detection
module lds_ctrl
	import lds_pkg::*;
#(
	parameter logic [21:0] SHDN_CYC  = LDS_SHDN_CYC,
	parameter logic [21:0] DET_CYC   = LDS_DET_CYC,
	parameter logic [21:0] SS_CYC    = LDS_SS_CYC,
	parameter logic [21:0] BLANK_CYC = LDS_BLANK_CYC
)
(
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        nrst_in,
	input  wire logic        clk_en_in,
	// host and supply
	input  wire logic        en_pwm_in,
	input  wire logic        supply_undervoltage_lockout_in,
	input  wire logic        over_temp_in,
	// comparators
	input  wire logic [3:0]  cs_low_in,
	input  wire logic [3:0]  ch_float_in,
	input  wire logic        short_sense_input_in,
	// outputs
	output logic      [3:0]  sink_en_out,
	output logic      [3:0]  ch_unused_out,
	output logic             fault_n_out,
	output logic             headroom_feedback_output_max_out,
	output logic             open_led_protection_on_out
);

	lds_state_t  state;
	lds_state_t  next_state;
	logic [21:0] phase_cnt;
	logic [21:0] low_cnt;
	logic [9:0]  mask_cnt;
	logic [9:0]  open_acc;
	logic [9:0]  short_acc;
	logic        pwm_q;
	logic        fault_latch;
	logic        shdn_hit;
	logic        pwm_rise;
	logic        prot_on;
	logic        count_ok;
	logic [3:0]  open_ch;
	logic        open_trip;
	logic        short_trip;

	// =========================================================
	// enable low-time and edge detection
	assign pwm_rise = en_pwm_in && !pwm_q;
	assign shdn_hit = !en_pwm_in && (low_cnt == SHDN_CYC - 22'h000001); // [R1]
	assign prot_on  = (state == LDS_ST_RUN); // [R9]
	assign count_ok = prot_on && en_pwm_in && !pwm_rise && (mask_cnt == 10'h000); // [R11]

	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			pwm_q   <= 1'b0;
			low_cnt <= 22'h000000;
		end
		else if (clk_en_in)
		begin
			pwm_q <= en_pwm_in;
			// saturates so shutdown persists; shorter lows only dim
			if (en_pwm_in)
				low_cnt <= 22'h000000; // [R17]
			else if (low_cnt != SHDN_CYC - 22'h000001)
				low_cnt <= low_cnt + 22'h000001;
		end
	end

	// =========================================================
	// sequencer
	always_comb
	begin
		next_state = state;
		if (supply_undervoltage_lockout_in || shdn_hit)
			next_state = LDS_ST_OFF; // [R2] [R1]
		else
		begin
			case (state)
				LDS_ST_OFF:
					if (en_pwm_in)
						next_state = LDS_ST_DETECT;
				LDS_ST_DETECT:
					if (phase_cnt == DET_CYC - 22'h000001)
						next_state = LDS_ST_SOFT; // [R6]
				LDS_ST_SOFT:
					if (phase_cnt == SS_CYC - 22'h000001)
						next_state = LDS_ST_BLANK; // [R7]
				LDS_ST_BLANK:
					if (en_pwm_in && phase_cnt == BLANK_CYC - 22'h000001)
						next_state = LDS_ST_RUN; // [R8]
				LDS_ST_RUN:
					next_state = LDS_ST_RUN;
				default:
					next_state = LDS_ST_OFF;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state                            <= LDS_ST_OFF;
			phase_cnt                        <= 22'h000000;
			headroom_feedback_output_max_out <= 1'b0;
			open_led_protection_on_out       <= 1'b0;
		end
		else if (clk_en_in)
		begin
			state                            <= next_state;
			headroom_feedback_output_max_out <= (next_state == LDS_ST_SOFT); // [R7]
			open_led_protection_on_out       <= (next_state == LDS_ST_RUN); // [R9]
			if (state != next_state || state == LDS_ST_OFF || state == LDS_ST_RUN)
				phase_cnt <= 22'h000000;
			else if (state != LDS_ST_BLANK || en_pwm_in)
				phase_cnt <= phase_cnt + 22'h000001; // [R8]
		end
	end

	// =========================================================
	// per-channel unused capture and open sensing
	generate
		for (genvar i = 0; i < LDS_NUM_CH; i++)
		begin : g_ch
			assign open_ch[i] = cs_low_in[i] && !ch_unused_out[i]; // [R18]
			always_ff @(posedge clk_sys_in or negedge nrst_in)
			begin
				if (!nrst_in)
					ch_unused_out[i] <= 1'b0;
				else if (clk_en_in)
				begin
					if (state == LDS_ST_OFF)
						ch_unused_out[i] <= 1'b0;
					else if (state == LDS_ST_DETECT && ch_float_in[i])
						ch_unused_out[i] <= 1'b1; // [R6]
				end
			end
		end
	endgenerate

	// =========================================================
	// fault timers; accumulate across pwm periods
	assign open_trip  = count_ok && (|open_ch) && (open_acc == LDS_OPEN_CYC - 10'h001);
	assign short_trip = count_ok && short_sense_input_in
		&& (short_acc == LDS_SHORT_CYC - 10'h001);

	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			mask_cnt  <= 10'h000;
			open_acc  <= 10'h000;
			short_acc <= 10'h000;
		end
		else if (clk_en_in)
		begin
			// the rise cycle is already masked by pwm_rise, so load one less
			if (pwm_rise)
				mask_cnt <= LDS_MASK_CYC - 10'h001; // [R11]
			else if (mask_cnt != 10'h000)
				mask_cnt <= mask_cnt - 10'h001;
			if (!prot_on)
			begin
				open_acc  <= 10'h000; // [R9]
				short_acc <= 10'h000;
			end
			else
			begin
				if (count_ok && (|open_ch) && !open_trip)
					open_acc <= open_acc + 10'h001; // [R10]
				if (count_ok && short_sense_input_in && !short_trip)
					short_acc <= short_acc + 10'h001; // [R13]
			end
		end
	end

	// set wins over the shutdown release
	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
			fault_latch <= 1'b0;
		else if (clk_en_in)
		begin
			if (open_trip || short_trip)
				fault_latch <= 1'b1; // [R12] [R14]
			else if (shdn_hit)
				fault_latch <= 1'b0; // [R15]
		end
	end

	// =========================================================
	// outputs; over-temperature gates without latching
	always_ff @(posedge clk_sys_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			sink_en_out <= 4'h0;
			fault_n_out <= 1'b1;
		end
		else if (clk_en_in)
		begin
			sink_en_out <= {LDS_NUM_CH{state != LDS_ST_OFF && en_pwm_in
				&& !supply_undervoltage_lockout_in && !fault_latch && !over_temp_in
				&& !open_trip && !short_trip}}; // [R3] [R4] [R2] [R16]
			fault_n_out <= !(fault_latch || open_trip || short_trip || over_temp_in); // [R16]
		end
	end

	// =========================================================
	// checks
	supply_undervoltage_lockout_off_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [R2]
		clk_en_in && supply_undervoltage_lockout_in |=> sink_en_out == 4'h0)
		else $error("sinks on during undervoltage");
	shdn_off_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [R1]
		clk_en_in && shdn_hit |=> state == LDS_ST_OFF && !fault_latch)
		else $error("no shutdown after long low");
	pwm_sink_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [R3]
		clk_en_in && state == LDS_ST_RUN && !en_pwm_in |=> sink_en_out == 4'h0)
		else $error("sinks on while pwm low");
	soft_fb_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [R7]
		headroom_feedback_output_max_out == (state == LDS_ST_SOFT))
		else $error("feedback not forced in soft start");
	soft_entry_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [R6]
		$rose(headroom_feedback_output_max_out) |-> $past(state) == LDS_ST_DETECT
		&& $past(phase_cnt) == DET_CYC - 22'h000001)
		else $error("soft start entered before detection ended");
	pwm_low_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [R10]
		clk_en_in && prot_on && !en_pwm_in
		|=> open_acc == $past(open_acc) && short_acc == $past(short_acc))
		else $error("fault timer ran while pwm low");
	blank_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [R8]
		clk_en_in && state == LDS_ST_BLANK && !en_pwm_in && !shdn_hit
		&& !supply_undervoltage_lockout_in |=> phase_cnt == $past(phase_cnt))
		else $error("blanking counted while pwm low");
	no_prot_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [R9]
		state != LDS_ST_RUN |=> open_acc == 10'h000 || !$past(clk_en_in))
		else $error("fault timer ran before protection on");
	mask_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [R11]
		clk_en_in && state == LDS_ST_RUN && mask_cnt != 10'h000
		&& !supply_undervoltage_lockout_in && !shdn_hit
		|=> open_acc == $past(open_acc) && short_acc == $past(short_acc))
		else $error("fault timer ran during mask");
	open_trip_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [R12]
		clk_en_in && open_trip |=> fault_latch && !fault_n_out && sink_en_out == 4'h0)
		else $error("open fault not latched");
	short_trip_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [R14]
		clk_en_in && count_ok && short_sense_input_in && short_acc == LDS_SHORT_CYC - 10'h001
		|=> fault_latch && !fault_n_out)
		else $error("short fault not latched");
	latch_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [R15]
		fault_latch && !shdn_hit |=> fault_latch)
		else $error("fault released without shutdown");
	otp_off_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // [R16]
		clk_en_in && over_temp_in |=> !fault_n_out && sink_en_out == 4'h0)
		else $error("over-temperature not acted on");

endmodule // lds_ctrl

/* File: core/lds_pkg.sv */
// constants for the led sink sequencer and fault control
// assumes a single 25 MHz system clock
package lds_pkg;

	// =========================================================
	// timebase
	localparam longint unsigned LDS_CLK_HZ      = 64'd25000000;
	localparam int              LDS_NUM_CH      = 4;

	// =========================================================
	// nominal times
	localparam longint unsigned LDS_T_SHDN_MS   = 64'd32;
	localparam longint unsigned LDS_T_DET_US    = 64'd256;
	localparam longint unsigned LDS_T_SS_MS     = 64'd128;
	localparam longint unsigned LDS_T_BLANK_MS  = 64'd32;
	localparam longint unsigned LDS_T_MASK_US   = 64'd4;
	localparam longint unsigned LDS_T_OPEN_US   = 64'd20;
	localparam longint unsigned LDS_T_SHORT_US  = 64'd2;

	// =========================================================
	// cycle counts, least times rounded up
	localparam logic [21:0] LDS_SHDN_CYC  =
		22'((LDS_T_SHDN_MS * LDS_CLK_HZ + 64'd999) / 64'd1000);
	localparam logic [21:0] LDS_DET_CYC   =
		22'((LDS_T_DET_US * LDS_CLK_HZ + 64'd999999) / 64'd1000000);
	localparam logic [21:0] LDS_SS_CYC    =
		22'((LDS_T_SS_MS * LDS_CLK_HZ + 64'd999) / 64'd1000);
	localparam logic [21:0] LDS_BLANK_CYC =
		22'((LDS_T_BLANK_MS * LDS_CLK_HZ + 64'd999) / 64'd1000);
	localparam logic [9:0]  LDS_MASK_CYC  =
		10'((LDS_T_MASK_US * LDS_CLK_HZ + 64'd999999) / 64'd1000000);
	localparam logic [9:0]  LDS_OPEN_CYC  =
		10'((LDS_T_OPEN_US * LDS_CLK_HZ + 64'd999999) / 64'd1000000);
	localparam logic [9:0]  LDS_SHORT_CYC =
		10'((LDS_T_SHORT_US * LDS_CLK_HZ + 64'd999999) / 64'd1000000);

	// =========================================================
	// sequencer states
	typedef enum logic [2:0] {
		LDS_ST_OFF,
		LDS_ST_DETECT,
		LDS_ST_SOFT,
		LDS_ST_BLANK,
		LDS_ST_RUN
	} lds_state_t;

endpackage

/* File: test/lds_host_pwm.sv */
// host pwm dimming source that drives the enable pin
// assumes the bench sets run and the high and low phase lengths in clock cycles
`timescale 1ns/1ns

module lds_host_pwm
(
	// clock and control
	input  wire logic        clk_in,
	input  wire logic        run_in,
	input  wire logic        supply_ok_in,
	input  wire logic [15:0] hi_cyc_in,
	input  wire logic [15:0] lo_cyc_in,
	// enable pin
	output logic             en_pwm_out
);
	// =========================================================
	// pwm generator
	logic [15:0] cnt = 16'h0;

	// pin stays low until supplies are valid
	always @(posedge clk_in)
	begin
		if (!run_in || !supply_ok_in)
		begin
			en_pwm_out <= #1 1'b0;
			cnt        <= 16'h0;
		end
		else
		begin
			en_pwm_out <= #1 (cnt < hi_cyc_in);
			cnt        <= (cnt + 16'h1 >= hi_cyc_in + lo_cyc_in) ? 16'h0 : cnt + 16'h1;
		end
	end
endmodule // lds_host_pwm

/* File: test/tb_top.sv */
// self-checking bench for the led sink sequencer and fault control
// assumes lds_ctrl with shortened phase counts and the host pwm model
`timescale 1ns/1ns

module tb_top
	import lds_pkg::*;
;
	// =========================================================
	// stimulus and wiring
	localparam int SHDN  = 40;
	localparam int BLANK = 16;
	localparam int DET   = 8;
	localparam int SS    = 200;
	logic        clk_sys_in = 1'b0;
	logic        clk_en     = 1'b1;
	logic        nrst_in    = 1'b0;
	logic        bench_en   = 1'b0;
	logic        host_run   = 1'b0;
	logic        supply_undervoltage_lockout       = 1'b0;
	logic        otp        = 1'b0;
	logic        shrt       = 1'b0;
	logic [3:0]  cs_low     = 4'h0;
	logic [3:0]  ch_float   = 4'h0;
	logic [15:0] hi         = 16'h0;
	logic [15:0] lo         = 16'h0;
	logic        host_en;
	logic [3:0]  sink;
	logic [3:0]  unused;
	logic        fault_n;
	logic        fb;
	logic        prot;
	int          bad_count   = 0;
	int          comparisons = 0;
	int          n;
	logic [3:0]  rows [6] = '{4'b1011, 4'b0001, 4'b1100, 4'b1011, 4'b0100, 4'b1011};

	always #20 clk_sys_in = ~clk_sys_in;

	lds_host_pwm i_host (.clk_in(clk_sys_in), .run_in(host_run), .supply_ok_in(~supply_undervoltage_lockout),
		.hi_cyc_in(hi), .lo_cyc_in(lo), .en_pwm_out(host_en));

	lds_ctrl #(.SHDN_CYC(22'(SHDN)), .DET_CYC(22'(DET)), .SS_CYC(22'(SS)),
		.BLANK_CYC(22'(BLANK)))
	i_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .clk_en_in(clk_en),
		.en_pwm_in(host_run ? host_en : bench_en), .supply_undervoltage_lockout_in(supply_undervoltage_lockout),
		.over_temp_in(otp), .cs_low_in(cs_low), .ch_float_in(ch_float),
		.short_sense_input_in(shrt), .sink_en_out(sink), .ch_unused_out(unused),
		.fault_n_out(fault_n), .headroom_feedback_output_max_out(fb),
		.open_led_protection_on_out(prot));

	// =========================================================
	// helpers
	task cyc(input int k);
		repeat (k) @(posedge clk_sys_in);
		#1;
	endtask

	task print_verdict();
		$display("compared %0d, mismatched %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input bit ok, input string msg);
		comparisons++;
		if (!ok)
		begin
			bad_count++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask

	// which: 0 feedback max, 1 fault_n, 2 protection on
	task wait_sig(input int which, input logic want, input int lim, output int cnt);
		logic s;
		cnt = 0;
		s = ~want;
		while (s !== want && cnt < lim)
		begin
			cyc(1);
			cnt++;
			s = (which == 0) ? fb : (which == 1) ? fault_n : prot;
		end
		if (s !== want)
		begin
			bad_count++;
			$display("[ERR] %0t wait ran out", $time);
			print_verdict();
		end
	endtask

	// detectors held active through start-up must be ignored
	task power_up(input logic [3:0] flt);
		ch_float = flt;
		cs_low = 4'hF;
		shrt = 1'b1;
		hi = 16'd400;
		lo = 16'd8;
		host_run = 1'b1;
		// model drives the pin one edge later; detection starts on the second edge
		cyc(DET + 1);
		chk(fb === 1'b0, "feedback forced in detect");
		cyc(1);
		chk(fb === 1'b1 && unused === flt, "soft start or unused set");
		cyc(SS - 1);
		chk(fb === 1'b1 && fault_n === 1'b1, "soft start cut short");
		cyc(1);
		chk(fb === 1'b0, "soft start too long");
		hi = 16'd4;
		lo = 16'd4;
		wait_sig(2, 1'b1, 200, n);
		chk(n > BLANK + 4, "blanking counted pwm low time");
		host_run = 1'b0;
		bench_en = 1'b1;
		cs_low = 4'h0;
		shrt = 1'b0;
		chk(fault_n === 1'b1, "fault during blanking");
	endtask

	// =========================================================
	// sequence
	initial
	begin
		cyc(3);
		chk(sink === 4'h0 && fault_n === 1'b1 && fb === 1'b0 && prot === 1'b0, "reset");
		cyc(3);
		nrst_in = 1'b1;
		cyc(2);
		power_up(4'h8);
		foreach (rows[i])
		begin
			{bench_en, otp} = rows[i][3:2];
			cyc(1);
			chk(sink === {4{rows[i][1]}} && fault_n === rows[i][0], "row mismatch");
		end
		bench_en = 1'b0;
		cyc(SHDN - 2);
		bench_en = 1'b1;
		cyc(2);
		chk(prot === 1'b1 && sink === 4'hF, "short low reset sequencer");
		// a long low with the clock enable off must not count towards shutdown
		clk_en = 1'b0;
		bench_en = 1'b0;
		cyc(SHDN + 4);
		chk(prot === 1'b1 && sink === 4'hF, "state moved with clock enable low");
		clk_en = 1'b1;
		bench_en = 1'b1;
		cyc(2);
		chk(prot === 1'b1 && sink === 4'hF, "sequencer lost after clock enable");
		bench_en = 1'b0;
		cyc(2);
		bench_en = 1'b1;
		shrt = 1'b1;
		cyc(int'(LDS_MASK_CYC) + int'(LDS_SHORT_CYC) - 1);
		chk(fault_n === 1'b1, "short counted inside mask");
		cyc(1);
		chk(fault_n === 1'b0, "short fault not raised");
		chk(sink === 4'h0, "sinks on after short fault");
		shrt = 1'b0;
		bench_en = 1'b0;
		cyc(SHDN - 4);
		bench_en = 1'b1;
		cyc(3);
		chk(fault_n === 1'b0 && sink === 4'h0, "fault released early");
		bench_en = 1'b0;
		cyc(SHDN + 3);
		chk(fault_n === 1'b1 && prot === 1'b0 && sink === 4'h0, "no shutdown");
		power_up(4'h8);
		// pin stays high so only the undervoltage can turn the sinks off
		supply_undervoltage_lockout = 1'b1;
		cyc(2);
		chk(sink === 4'h0 && prot === 1'b0, "undervoltage left device on");
		bench_en = 1'b0;
		supply_undervoltage_lockout = 1'b0;
		cyc(2);
		power_up(4'h8);
		cs_low = 4'h8;
		cyc(700);
		chk(fault_n === 1'b1, "unused channel tripped open");
		cs_low = 4'h9;
		cyc(int'(LDS_OPEN_CYC) - 1);
		chk(fault_n === 1'b1, "open tripped early");
		cyc(1);
		chk(fault_n === 1'b0, "open fault not raised");
		chk(sink === 4'h0, "sinks on after open fault");
		cs_low = 4'h0;
		nrst_in = 1'b0;
		cyc(1);
		chk(sink === 4'h0 && fault_n === 1'b1 && prot === 1'b0 && unused === 4'h0,
			"mid-run reset");
		nrst_in = 1'b1;
		cyc(2);
		chk(sink === 4'hF && fb === 1'b0 && fault_n === 1'b1, "restart after reset");
		print_verdict();
	end
endmodule // tb_top
